//--- bench/cpu_bus_model.sv
`timescale 1ns/1ps
`default_nettype none

module cpu_bus_model
  import timer0_pkg::*;
(
  input wire logic core_clk,
  output var avmm_req_type avmm_req,
  input wire avmm_rsp_type avmm_rsp
);
  initial avmm_req = '0;

  // Holds the request until the slave stops waiting; no cycle count is assumed
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [15:0] d,
                        input logic [3:0] be, output logic [DATA_W-1:0] rdata);
    @(posedge core_clk);
    avmm_req <= '{read: !wr, write: wr, address: a, writedata: {16'h0000, d}, byteenable: be};
    do
      @(posedge core_clk);
    while (avmm_rsp.waitrequest !== 1'b0);
    rdata = avmm_rsp.readdata;
    avmm_req <= '0;
  endtask
endmodule

`default_nettype wire

//--- bench/test_timer0_regs.sv
`timescale 1ns/1ps
`default_nettype none

module test_timer0_regs
  import timer0_pkg::*;
();
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic clk_en = 1'b1;
  logic global_irq_enable = 1'b0;
  logic overflow_ack = 1'b0;
  logic compare_ack = 1'b0;
  logic ext_clock_pin_a = 1'b0;
  logic ext_clock_pin_b = 1'b0;
  avmm_req_type avmm_req;
  avmm_rsp_type avmm_rsp;
  logic overflow_irq;
  logic compare_irq;
  logic waveform_out_pin;
  logic timer1_tick_enable;
  logic [DATA_W-1:0] q;
  int fail_count = 0;
  int compares = 0;
  int ticks1 = 0;

  always #2.5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    if (timer1_tick_enable === 1'b1)
      ticks1 <= ticks1 + 1;
  end

  timer0_regs dut_u (.core_clk, .nrst, .clk_en, .avmm_req, .avmm_rsp, .global_irq_enable, .overflow_ack,
    .compare_ack, .ext_clock_pin_a, .ext_clock_pin_b, .overflow_irq, .compare_irq, .waveform_out_pin,
    .timer1_tick_enable);
  cpu_bus_model cpu_u (.core_clk, .avmm_req, .avmm_rsp);

  // ********
  // Helpers
  // ********
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic check_in(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] lo, input logic [DATA_W-1:0] hi);
    compares++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      fail_count++;
      $display("Error at %0t: got %0h expected %0h to %0h", $time, got, lo, hi);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    cpu_u.access(1'b1, a, {8'h00, d}, 4'h1, q);
  endtask

  // Lane 1 enabled so the second timer's select is written too
  task automatic ctl(input logic [15:0] v);
    cpu_u.access(1'b1, OFS_CONTROL, v, 4'h3, q);
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    cpu_u.access(1'b0, a, 16'h0000, 4'hF, q);
    check(q, e);
  endtask

  task automatic rd_in(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] lo, input logic [DATA_W-1:0] hi);
    cpu_u.access(1'b0, a, 16'h0000, 4'hF, q);
    check_in(q, lo, hi);
  endtask

  task automatic irq_is(input logic [1:0] e);
    #1;
    check({overflow_irq, compare_irq}, e);
  endtask

  task automatic pulse_ack(input logic ovf);
    @(posedge core_clk);
    overflow_ack <= ovf;
    compare_ack <= !ovf;
    @(posedge core_clk);
    overflow_ack <= 1'b0;
    compare_ack <= 1'b0;
    cyc(2);
  endtask

  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge core_clk);
      ext_clock_pin_a <= 1'b1;
      ext_clock_pin_b <= 1'b1;
      cyc(4);
      ext_clock_pin_a <= 1'b0;
      ext_clock_pin_b <= 1'b0;
      cyc(4);
    end
  endtask

  task automatic run_div1();
    ctl(16'h0000);
    wr(OFS_COUNTER, 8'h00);
    wr(OFS_COMPARE, 8'h10);
    ctl({13'h0000, CS_DIV1});
    cyc(300);
    ctl(16'h0000);
  endtask

  // ********
  // Scenarios
  // ********
  task automatic t_regs();
    rd_chk(OFS_MASK, 32'h0);
    rd_chk(OFS_FLAGS, 32'h0);
    wr(OFS_COUNTER, 8'h5A);
    rd_chk(OFS_COUNTER, 32'h5A);
    wr(OFS_COMPARE, 8'hA5);
    rd_chk(OFS_COMPARE, 32'hA5);
    wr(OFS_MASK, 8'hFF);
    rd_chk(OFS_MASK, 32'hFF);
    wr(OFS_MASK, 8'h00);
    wr(5'h18, 8'h77);
    rd_chk(5'h18, 32'h0);
    wr(OFS_PRESC_RST, 8'h01);
    rd_chk(OFS_PRESC_RST, 32'h0);
  endtask

  task automatic t_flags();
    run_div1();
    rd_in(OFS_COUNTER, 45, 48);
    rd_chk(OFS_FLAGS, 32'h3);
    wr(OFS_FLAGS, 8'h00);
    rd_chk(OFS_FLAGS, 32'h3);
    wr(OFS_FLAGS, 8'h02);
    rd_chk(OFS_FLAGS, 32'h1);
    wr(OFS_FLAGS, 8'h01);
    rd_chk(OFS_FLAGS, 32'h0);
  endtask

  task automatic t_irq();
    run_div1();
    wr(OFS_MASK, 8'h03);
    cyc(2);
    irq_is(2'b00);
    @(posedge core_clk);
    global_irq_enable <= 1'b1;
    cyc(2);
    irq_is(2'b11);
    wr(OFS_MASK, 8'h01);
    cyc(2);
    irq_is(2'b01);
    wr(OFS_MASK, 8'h03);
    pulse_ack(1'b0);
    irq_is(2'b10);
    rd_chk(OFS_FLAGS, 32'h2);
    pulse_ack(1'b1);
    irq_is(2'b00);
    rd_chk(OFS_FLAGS, 32'h0);
    @(posedge core_clk);
    global_irq_enable <= 1'b0;
    wr(OFS_MASK, 8'h00);
  endtask

  task automatic t_wave();
    run_div1();
    #1;
    check(waveform_out_pin, 1'b0);
    wr(OFS_COUNTER, 8'h00);
    ctl({9'h000, COM_TOGGLE, WAVE_NORMAL, CS_DIV1});
    cyc(100);
    ctl({9'h000, COM_TOGGLE, WAVE_NORMAL, CS_STOP});
    #1;
    check(waveform_out_pin, 1'b1);
  endtask

  // A counter write just before the value meets the compare value hides that match
  task automatic t_block();
    ctl(16'h0000);
    wr(OFS_COUNTER, 8'h01);
    wr(OFS_COMPARE, 8'h00);
    wr(OFS_FLAGS, 8'h03);
    ctl({13'h0000, CS_DIV1});
    wr(OFS_COUNTER, 8'h00);
    ctl(16'h0000);
    rd_chk(OFS_FLAGS, 32'h0);
  endtask

  task automatic t_taps();
    clock_select_type sel [4] = '{CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024};
    int div [4] = '{8, 64, 256, 1024};
    for (int i = 0; i < 4; i++) begin
      wr(OFS_COUNTER, 8'h00);
      ctl({13'h0000, sel[i]});
      cyc(4 * div[i]);
      ctl(16'h0000);
      rd_in(OFS_COUNTER, 4, 5);
    end
    cyc(40);
    rd_chk(OFS_COUNTER, q);
  endtask

  task automatic t_shared();
    int t0;
    t0 = ticks1;
    wr(OFS_COUNTER, 8'h00);
    wr(OFS_PRESC_RST, 8'h01);
    ctl({5'h00, CS_DIV64, 5'h00, CS_DIV64});
    repeat (8) begin
      cyc(40);
      wr(OFS_PRESC_RST, 8'h01);
    end
    ctl(16'h0000);
    rd_chk(OFS_COUNTER, 32'h0);
    check(ticks1 - t0, 0);
    t0 = ticks1;
    ctl({5'h00, CS_DIV1, 8'h00});
    cyc(100);
    ctl(16'h0000);
    check_in(ticks1 - t0, 100, 105);
    rd_chk(OFS_COUNTER, 32'h0);
  endtask

  task automatic t_ext();
    int t0;
    int n;
    wr(OFS_COUNTER, 8'h00);
    ctl({5'h00, CS_EXT_RISE, 5'h00, CS_EXT_RISE}); // pins held low
    t0 = ticks1;
    pulses(5);
    @(posedge core_clk);
    ext_clock_pin_a <= 1'b1;
    ext_clock_pin_b <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (timer1_tick_enable !== 1'b1 && n < 8);
    check_in(n, 3, 5);
    cyc(4);
    ext_clock_pin_a <= 1'b0;
    ext_clock_pin_b <= 1'b0;
    cyc(6);
    rd_chk(OFS_COUNTER, 32'h6);
    check(ticks1 - t0, 6);
    ctl(16'h0000);
    wr(OFS_COUNTER, 8'h00);
    ctl({13'h0000, CS_EXT_FALL});
    pulses(3);
    rd_chk(OFS_COUNTER, 32'h3);
    ctl(16'h0000);
  endtask

  // Phase PWM turns at the top with no overflow; 50 frozen cycles add no ticks
  task automatic t_pwm();
    wr(OFS_COUNTER, 8'h00);
    wr(OFS_COMPARE, 8'hF0);
    wr(OFS_FLAGS, 8'h03);
    ctl({11'h000, WAVE_PHASE_PWM, CS_DIV1});
    cyc(300);
    ctl(16'h0000);
    rd_chk(OFS_COUNTER, 32'hCF);
    rd_chk(OFS_FLAGS, 32'h1);
    wr(OFS_FLAGS, 8'h03);
    ctl({11'h000, WAVE_PHASE_PWM, CS_DIV1});
    @(posedge core_clk);
    clk_en <= 1'b0;
    cyc(50);
    clk_en <= 1'b1;
    cyc(300);
    ctl(16'h0000);
    rd_chk(OFS_COUNTER, 32'h61);
    rd_chk(OFS_FLAGS, 32'h2);
  endtask

  initial begin
    repeat (40000) @(posedge core_clk);
    fail_count++;
    final_report();
  end

  initial begin
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    t_regs();
    t_flags();
    t_irq();
    t_wave();
    t_block();
    t_taps();
    t_shared();
    t_ext();
    t_pwm();
    final_report();
  end
endmodule

`default_nettype wire

//--- bench/timer0_regs_props.sv
`timescale 1ns/1ps
`default_nettype none

module timer0_regs_props
  import timer0_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire avmm_req_type avmm_req,
  input wire avmm_rsp_type avmm_rsp,
  input wire logic global_irq_enable,
  input wire logic overflow_irq,
  input wire logic compare_irq
);
  // ********
  // Bus handshake and interrupt gating
  // ********
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  logic rd_done;
  logic mapped;
  assign rd_done = avmm_req.read && !avmm_rsp.waitrequest;
  assign mapped = avmm_req.address inside {OFS_COUNTER, OFS_COMPARE, OFS_MASK, OFS_FLAGS, OFS_CONTROL,
    OFS_PRESC_RST};

  sequence s_request;
    (avmm_req.read || avmm_req.write) && avmm_rsp.waitrequest && clk_en;
  endsequence
  sequence s_answer;
    !avmm_rsp.waitrequest ##1 avmm_rsp.waitrequest;
  endsequence

  property p_take;
    s_request ##1 clk_en |-> s_answer;
  endproperty
  a_take: assert property (p_take) else $error("bus request not answered in one wait cycle");
  property p_one_wait;
    !avmm_rsp.waitrequest && $past(clk_en) |-> $past(avmm_rsp.waitrequest);
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("waitrequest low for two cycles");
  property p_idle_zero;
    avmm_rsp.waitrequest |-> avmm_rsp.readdata == '0;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("read data not zero while waiting");
  property p_unmapped;
    rd_done && !mapped |-> avmm_rsp.readdata == '0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_flags_rsv;
    rd_done && avmm_req.address == OFS_FLAGS |-> avmm_rsp.readdata[DATA_W-1:2] == '0;
  endproperty
  a_flags_rsv: assert property (p_flags_rsv) else $error("flag register upper bits set");
  property p_presc_zero;
    rd_done && avmm_req.address == OFS_PRESC_RST |-> avmm_rsp.readdata == '0;
  endproperty
  a_presc_zero: assert property (p_presc_zero) else $error("prescaler reset bit read as one");
  property p_ovf_gate;
    $rose(overflow_irq) |-> $past(global_irq_enable);
  endproperty
  a_ovf_gate: assert property (p_ovf_gate) else $error("overflow irq without global enable");
  property p_cmp_gate;
    compare_irq && $past(clk_en) |-> $past(global_irq_enable);
  endproperty
  a_cmp_gate: assert property (p_cmp_gate) else $error("compare irq without global enable");
  property p_irq_drop;
    !global_irq_enable && clk_en |=> !overflow_irq && !compare_irq;
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("irq stays up after global disable");
endmodule

bind timer0_regs timer0_regs_props props_u (.core_clk, .nrst, .clk_en, .avmm_req, .avmm_rsp,
  .global_irq_enable, .overflow_irq, .compare_irq);

`default_nettype wire

//--- hdl/pin_edge_detect.sv
`timescale 1ns/1ps
`default_nettype none

module pin_edge_detect
  import timer0_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic pin,
  output logic rise,
  output logic fall
);

  logic pin_latched;
  pin_sync_type state_q;
  pin_sync_type state_d;

  // ****************************************
  // Sampling
  // ****************************************
  // Transparent while the clock is high, so a pin edge in the low phase waits up
  // to half a cycle to reach the flop; this sets the 2.5 to 3.5 cycle latency.
  always_latch begin
    if (!nrst) begin
      pin_latched = 1'b0;
    end else if (core_clk) begin
      pin_latched = pin;
    end
  end

  always_comb begin
    state_d = state_q;
    if (clk_en) begin
      state_d.stage1 = pin_latched;
      state_d.stage2 = state_q.stage1;
      state_d.stage3 = state_q.stage2;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // Edge detection
  // ****************************************
  // Only the settled second stage feeds the detector; stage3 is its history
  assign rise = state_q.stage2 & ~state_q.stage3;
  assign fall = ~state_q.stage2 & state_q.stage3;

endmodule

`default_nettype wire

//--- hdl/timer0_pkg.sv
package timer0_pkg;

  // ****************************************
  // Bus carriers
  // ****************************************
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;

  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
    logic [3:0] byteenable;
  } avmm_req_type;

  typedef struct packed {
    logic [DATA_W-1:0] readdata;
    logic waitrequest;
  } avmm_rsp_type;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [ADDR_W-1:0] OFS_COUNTER = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_COMPARE = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_MASK = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_PRESC_RST = 5'h14;

  localparam int MASK_OVF_BIT = 1;
  localparam int MASK_CMP_BIT = 0;
  localparam int FLAG_OVF_BIT = 1;
  localparam int FLAG_CMP_BIT = 0;
  localparam int PRESC_RST_BIT = 0;
  localparam int LANE0_BIT = 0;
  localparam int LANE1_BIT = 1;

  localparam int CTRL_CS0_LSB = 0;
  localparam int CTRL_WAVE_LSB = 3;
  localparam int CTRL_COM_LSB = 5;
  localparam int CTRL_CS1_LSB = 8;

  localparam logic [7:0] COUNTER_RESET = 8'h00;
  localparam logic [7:0] COMPARE_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] COUNT_ONE = 8'h01;

  // ****************************************
  // Modes
  // ****************************************
  typedef enum logic [2:0] {
    CS_STOP = 3'b000,
    CS_DIV1 = 3'b001,
    CS_DIV8 = 3'b010,
    CS_DIV64 = 3'b011,
    CS_DIV256 = 3'b100,
    CS_DIV1024 = 3'b101,
    CS_EXT_FALL = 3'b110,
    CS_EXT_RISE = 3'b111
  } clock_select_type;

  typedef enum logic [1:0] {
    WAVE_NORMAL = 2'b00,
    WAVE_PHASE_PWM = 2'b01,
    WAVE_CTC = 2'b10,
    WAVE_FAST_PWM = 2'b11
  } wave_mode_type;

  typedef enum logic [1:0] {
    COM_OFF = 2'b00,
    COM_TOGGLE = 2'b01,
    COM_CLEAR = 2'b10,
    COM_SET = 2'b11
  } com_mode_type;

  // ****************************************
  // Shared prescaler
  // ****************************************
  localparam int PRESC_W = 10;
  localparam logic [PRESC_W-1:0] PRESC_RESET = 10'h000;
  localparam logic [PRESC_W-1:0] PRESC_STEP = 10'h001;
  localparam logic [PRESC_W-1:0] TAP_DIV8 = 10'h007;
  localparam logic [PRESC_W-1:0] TAP_DIV64 = 10'h03F;
  localparam logic [PRESC_W-1:0] TAP_DIV256 = 10'h0FF;
  localparam logic [PRESC_W-1:0] TAP_DIV1024 = 10'h3FF;

  typedef struct packed {
    logic stage1;
    logic stage2;
    logic stage3;
  } pin_sync_type;

endpackage

//--- hdl/timer0_regs.sv
// Operation
// - Counter register is readable and writable by software at any time.
// - A counter write suppresses the compare match on the next timer tick; in CTC mode that match still clears the counter.
// - Compare register is compared with the counter on every timer tick; match drives irq and pin.
// - Overflow irq enable is mask bit 1; irq needs enable, global bit, flag.
// - Compare irq enable is mask bit 0; irq needs enable, global bit, flag.
// - Overflow flag, flags bit 1, sets on overflow, or bottom turn in phase PWM.
// - Compare flag, flags bit 0, sets when counter equals compare value.
// - Executing a flag's interrupt vector clears that flag.
// - Writing one to a flag clears it; writing zero leaves it.
// - One shared prescaler; each timer keeps its own clock select.
// - Select one counts every clock; selects 2 to 5 tap prescaler at 8, 64, 256, 1024.
// - Prescaler runs freely, so first prescaled tick comes 1 to N clocks later.
// - Prescaler reset restarts the division period for both timers.
// - Each clock pin is sampled by a high-phase latch then rising-edge flops.
// - One tick per rising pin edge at select 7, falling edge at select 6.
// - Pin edge reaches the counter 2.5 to 3.5 clocks later.
// - Pin edges count directly, never divided by the prescaler.
// - Select zero stops the timer; 2 to 5 pick divide 8, 64, 256, 1024.
// - Writing one resets the prescaler; the bit self-clears and reads zero.
`timescale 1ns/1ps
`default_nettype none

module timer0_regs
  import timer0_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire avmm_req_type avmm_req,
  output avmm_rsp_type avmm_rsp,
  input wire logic global_irq_enable,
  input wire logic overflow_ack,
  input wire logic compare_ack,
  input wire logic ext_clock_pin_a,
  input wire logic ext_clock_pin_b,
  output logic overflow_irq,
  output logic compare_irq,
  output logic waveform_out_pin,
  output logic timer1_tick_enable
);

  typedef struct packed {
    logic [7:0] counter_value;
    logic [7:0] compare_value;
    logic [7:0] interrupt_mask;
    logic overflow_flag;
    logic compare_flag;
    clock_select_type clock_select;
    clock_select_type timer1_clock_select;
    wave_mode_type wave_mode;
    com_mode_type com_mode;
    logic [PRESC_W-1:0] prescaler;
    logic match_blocked;
    logic count_down;
    logic waveform;
    logic waitrequest;
    logic [DATA_W-1:0] readdata;
    logic overflow_irq;
    logic compare_irq;
    logic timer1_tick;
  } state_type;

  state_type state_q;
  state_type state_d;

  logic pin_a_rise;
  logic pin_a_fall;
  logic pin_b_rise;
  logic pin_b_fall;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic tap_hit(input logic [PRESC_W-1:0] count, input logic [PRESC_W-1:0] mask);
    tap_hit = (count & mask) == mask;
  endfunction

  // Shared by both timers; each passes its own select and pin edges
  function automatic logic tick_for(input clock_select_type sel, input logic [PRESC_W-1:0] count,
                                    input logic rise, input logic fall);
    unique case (sel)
      CS_STOP: tick_for = 1'b0;
      CS_DIV1: tick_for = 1'b1;
      CS_DIV8: tick_for = tap_hit(count, TAP_DIV8);
      CS_DIV64: tick_for = tap_hit(count, TAP_DIV64);
      CS_DIV256: tick_for = tap_hit(count, TAP_DIV256);
      CS_DIV1024: tick_for = tap_hit(count, TAP_DIV1024);
      CS_EXT_FALL: tick_for = fall;
      CS_EXT_RISE: tick_for = rise;
    endcase
  endfunction

  function automatic logic hits(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
    hits = addr == ofs;
  endfunction

  // ****************************************
  // Clock pin edge detectors
  // ****************************************
  pin_edge_detect pin_a_detect (
    .core_clk(core_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .pin(ext_clock_pin_a),
    .rise(pin_a_rise),
    .fall(pin_a_fall)
  );

  pin_edge_detect pin_b_detect (
    .core_clk(core_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .pin(ext_clock_pin_b),
    .rise(pin_b_rise),
    .fall(pin_b_fall)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic tick;
    logic access;
    logic wr;
    logic wr_lane0;
    logic wr_lane1;
    logic at_max;
    logic at_bottom;
    logic match;
    logic overflow_event;
    logic top_event;
    logic [7:0] cnt_next;
    tick = 1'b0;
    access = 1'b0;
    wr = 1'b0;
    wr_lane0 = 1'b0;
    wr_lane1 = 1'b0;
    at_max = 1'b0;
    at_bottom = 1'b0;
    match = 1'b0;
    overflow_event = 1'b0;
    top_event = 1'b0;
    cnt_next = state_q.counter_value;
    state_d = state_q;

    if (clk_en) begin
      // Prescaler never looks at either select, so both timers share its phase
      state_d.prescaler = state_q.prescaler + PRESC_STEP;

      tick = tick_for(state_q.clock_select, state_q.prescaler, pin_a_rise, pin_a_fall);
      state_d.timer1_tick = tick_for(state_q.timer1_clock_select, state_q.prescaler, pin_b_rise, pin_b_fall);

      at_max = state_q.counter_value == COUNT_MAX;
      at_bottom = state_q.counter_value == COUNT_BOTTOM;
      match = state_q.counter_value == state_q.compare_value;

      // ****************************************
      // Counting
      // ****************************************
      if (tick) begin
        unique case (state_q.wave_mode)
          WAVE_PHASE_PWM: begin
            if (state_q.count_down) begin
              if (at_bottom) begin
                state_d.count_down = 1'b0;
                overflow_event = 1'b1;
                cnt_next = COUNT_ONE;
              end else begin
                cnt_next = state_q.counter_value - COUNT_ONE;
              end
            end else if (at_max) begin
              state_d.count_down = 1'b1;
              cnt_next = COUNT_MAX - COUNT_ONE;
            end else begin
              cnt_next = state_q.counter_value + COUNT_ONE;
            end
          end
          WAVE_CTC: begin
            overflow_event = at_max;
            cnt_next = (match || at_max) ? COUNT_BOTTOM : state_q.counter_value + COUNT_ONE;
          end
          WAVE_NORMAL, WAVE_FAST_PWM: begin
            overflow_event = at_max;
            top_event = at_max;
            cnt_next = state_q.counter_value + COUNT_ONE;
          end
        endcase
        state_d.counter_value = cnt_next;
        // A blocked match is consumed by this tick whether or not it fired
        match = match && !state_q.match_blocked;
        state_d.match_blocked = 1'b0;
      end else begin
        match = 1'b0;
      end

      // ****************************************
      // Waveform pin
      // ****************************************
      if (state_q.wave_mode == WAVE_FAST_PWM) begin
        if (top_event) begin
          state_d.waveform = state_q.com_mode == COM_CLEAR;
        end else if (match) begin
          state_d.waveform = state_q.com_mode == COM_SET;
        end
      end else if (state_q.wave_mode == WAVE_PHASE_PWM) begin
        if (match) begin
          state_d.waveform = (state_q.com_mode == COM_SET) ^ state_q.count_down;
        end
      end else if (match) begin
        unique case (state_q.com_mode)
          COM_OFF: state_d.waveform = state_q.waveform;
          COM_TOGGLE: state_d.waveform = !state_q.waveform;
          COM_CLEAR: state_d.waveform = 1'b0;
          COM_SET: state_d.waveform = 1'b1;
        endcase
      end
      if (state_q.com_mode == COM_OFF) begin
        state_d.waveform = 1'b0;
      end

      // ****************************************
      // Flags: clears first, so a same-cycle event still sets
      // ****************************************
      access = (avmm_req.read || avmm_req.write) && !state_q.waitrequest;
      wr = avmm_req.write && access;
      wr_lane0 = wr && avmm_req.byteenable[LANE0_BIT];
      wr_lane1 = wr && avmm_req.byteenable[LANE1_BIT];

      if (overflow_ack) begin
        state_d.overflow_flag = 1'b0;
      end
      if (compare_ack) begin
        state_d.compare_flag = 1'b0;
      end
      if (wr_lane0 && hits(avmm_req.address, OFS_FLAGS)) begin
        if (avmm_req.writedata[FLAG_OVF_BIT]) begin
          state_d.overflow_flag = 1'b0;
        end
        if (avmm_req.writedata[FLAG_CMP_BIT]) begin
          state_d.compare_flag = 1'b0;
        end
      end
      if (overflow_event) begin
        state_d.overflow_flag = 1'b1;
      end
      if (match) begin
        state_d.compare_flag = 1'b1;
      end

      // ****************************************
      // Register writes
      // ****************************************
      if (wr_lane0) begin
        if (hits(avmm_req.address, OFS_COUNTER)) begin
          state_d.counter_value = avmm_req.writedata[7:0];
          state_d.match_blocked = 1'b1;
        end
        if (hits(avmm_req.address, OFS_COMPARE)) begin
          state_d.compare_value = avmm_req.writedata[7:0];
        end
        if (hits(avmm_req.address, OFS_MASK)) begin
          state_d.interrupt_mask = avmm_req.writedata[7:0];
        end
        if (hits(avmm_req.address, OFS_CONTROL)) begin
          state_d.clock_select = clock_select_type'(avmm_req.writedata[CTRL_CS0_LSB +: 3]);
          state_d.wave_mode = wave_mode_type'(avmm_req.writedata[CTRL_WAVE_LSB +: 2]);
          state_d.com_mode = com_mode_type'(avmm_req.writedata[CTRL_COM_LSB +: 2]);
        end
        // Restarting the shared count upsets any prescaled timer1 period too
        if (hits(avmm_req.address, OFS_PRESC_RST) && avmm_req.writedata[PRESC_RST_BIT]) begin
          state_d.prescaler = PRESC_RESET;
        end
      end
      if (wr_lane1 && hits(avmm_req.address, OFS_CONTROL)) begin
        state_d.timer1_clock_select = clock_select_type'(avmm_req.writedata[CTRL_CS1_LSB +: 3]);
      end

      // ****************************************
      // Bus handshake: one wait cycle, then a single ready cycle
      // ****************************************
      state_d.readdata = '0;
      if ((avmm_req.read || avmm_req.write) && state_q.waitrequest) begin
        state_d.waitrequest = 1'b0;
        if (avmm_req.read) begin
          unique case (1'b1)
            hits(avmm_req.address, OFS_COUNTER): state_d.readdata[7:0] = state_q.counter_value;
            hits(avmm_req.address, OFS_COMPARE): state_d.readdata[7:0] = state_q.compare_value;
            hits(avmm_req.address, OFS_MASK): state_d.readdata[7:0] = state_q.interrupt_mask;
            hits(avmm_req.address, OFS_FLAGS): begin
              state_d.readdata[FLAG_OVF_BIT] = state_q.overflow_flag;
              state_d.readdata[FLAG_CMP_BIT] = state_q.compare_flag;
            end
            hits(avmm_req.address, OFS_CONTROL): begin
              state_d.readdata[CTRL_CS0_LSB +: 3] = state_q.clock_select;
              state_d.readdata[CTRL_WAVE_LSB +: 2] = state_q.wave_mode;
              state_d.readdata[CTRL_COM_LSB +: 2] = state_q.com_mode;
              state_d.readdata[CTRL_CS1_LSB +: 3] = state_q.timer1_clock_select;
            end
            default: state_d.readdata = '0;
          endcase
        end
      end else begin
        state_d.waitrequest = 1'b1;
      end

      // ****************************************
      // Interrupt requests
      // ****************************************
      state_d.overflow_irq = global_irq_enable && state_q.interrupt_mask[MASK_OVF_BIT]
                             && state_d.overflow_flag;
      state_d.compare_irq = global_irq_enable && state_q.interrupt_mask[MASK_CMP_BIT]
                            && state_d.compare_flag;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q.counter_value <= COUNTER_RESET;
      state_q.compare_value <= COMPARE_RESET;
      state_q.interrupt_mask <= MASK_RESET;
      state_q.overflow_flag <= 1'b0;
      state_q.compare_flag <= 1'b0;
      state_q.clock_select <= CS_STOP;
      state_q.timer1_clock_select <= CS_STOP;
      state_q.wave_mode <= WAVE_NORMAL;
      state_q.com_mode <= COM_OFF;
      state_q.prescaler <= PRESC_RESET;
      state_q.match_blocked <= 1'b0;
      state_q.count_down <= 1'b0;
      state_q.waveform <= 1'b0;
      state_q.waitrequest <= 1'b1;
      state_q.readdata <= '0;
      state_q.overflow_irq <= 1'b0;
      state_q.compare_irq <= 1'b0;
      state_q.timer1_tick <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign avmm_rsp.readdata = state_q.readdata;
  assign avmm_rsp.waitrequest = state_q.waitrequest;
  assign overflow_irq = state_q.overflow_irq;
  assign compare_irq = state_q.compare_irq;
  assign waveform_out_pin = state_q.waveform;
  assign timer1_tick_enable = state_q.timer1_tick;

endmodule

`default_nettype wire
